// [src/tmon_pkg.sv]
// shared constants for the trigger output monitor
package tmon_pkg;

  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned NUM_GEN   = 4;
  localparam int unsigned SEL_W     = 2;
  localparam int unsigned TALLY_W   = 16;
  localparam int unsigned LIMIT_W   = 24;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SOURCE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CLEAR  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TALLY  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LIMIT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_QUEUE  = 8'h14;

  // field positions
  localparam int unsigned STS_RATE_BIT   = 0;
  localparam int unsigned STS_ABSENT_BIT = 1;
  localparam int unsigned CLR_RATE_BIT   = 0;
  localparam int unsigned CLR_TALLY_BIT  = 1;
  localparam int unsigned CLR_ABSENT_BIT = 2;
  localparam int unsigned QUEUE_EN_BIT   = 0;

  // reset values and tally saturation limit
  localparam logic [SEL_W-1:0]   RST_SOURCE = 2'h0;
  localparam logic [LIMIT_W-1:0] RST_LIMIT  = 24'h000000;
  localparam logic [TALLY_W-1:0] TALLY_MAX  = 16'hFFFF;

endpackage

// [src/tmon_edge_sel.sv]
// per-generator rising edge detect and source select
`timescale 1ns/1ps
module tmon_edge_sel #(
  parameter int unsigned NUM = 4,
  parameter int unsigned SW  = 2
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           ce,
  input  wire logic [NUM-1:0] pulse_former,
  input  wire logic [SW-1:0]  sel,
  output logic                start_edge
);

  logic [NUM-1:0] prev_q;
  logic [NUM-1:0] prev_d;
  logic [NUM-1:0] rise;
  logic           start_edge_d;
  logic           start_edge_q;

  // refuse a selector that cannot address every generator
  if (NUM > (1 << SW)) begin : g_chk
    $error("selector too narrow for generator count");
  end

  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : g_edge
      assign rise[g] = pulse_former[g] & ~prev_q[g];
    end
  endgenerate

  always_comb begin
    prev_d       = prev_q;
    start_edge_d = 1'b0;
    if (ce) begin
      prev_d       = pulse_former;
      start_edge_d = rise[sel];
    end
  end

  // a one-cycle pulse; held under ce low so nothing is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q       <= '0;
      start_edge_q <= 1'b0;
    end else if (ce) begin
      prev_q       <= prev_d;
      start_edge_q <= start_edge_d;
    end
  end

  assign start_edge = start_edge_q;

endmodule

// [src/tmon_top.sv]
// trigger output monitor: overrun, pulse tally, missing frame
`timescale 1ns/1ps
// Operation
// R01: flag overrun when input pulses beat the configured rate limit.
// R02: with queuing on, flag overrun only when queue is full on arrival.
// R03: reading the overrun flag returns it and leaves it set.
// R04: only the overrun clear command returns the overrun flag to no.
// R05: read-write source selector picks generator 0 to 3, resets to 0.
// R06: count each output pulse of the selected generator, 0 to 65535.
// R07: the tally clear command sets the pulse count to zero.
// R08: two start edges with no valid frame between them set missing flag.
// R09: missing flag holds until its clear command returns it to no.
// R10: missing-frame detection uses the generator chosen by the selector.
// R11: software picks the camera trigger generator, starts acquisition first.
// R12: the pulse count holds at 65535 instead of wrapping.
// R13: a one-cycle frame-valid event re-arms detection between start edges.
module tmon_top (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            ce,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [tmon_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [tmon_pkg::DATA_W-1:0]     pwdata,
  output logic      [tmon_pkg::DATA_W-1:0]     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [tmon_pkg::NUM_GEN-1:0]    pulse_former,
  input  wire logic                            trig_in_pulse,
  input  wire logic                            queue_full,
  input  wire logic                            frame_valid,
  output logic                                 rate_overrun_flag,
  output logic                                 absent_frame_flag,
  output logic                                 queue_enable
);
  import tmon_pkg::*;

  // apb slave state
  logic              pready_q;
  logic              pready_d;
  logic              pslverr_q;
  logic              pslverr_d;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;

  // software settings
  logic [SEL_W-1:0]   source_q;
  logic [SEL_W-1:0]   source_d;
  logic [LIMIT_W-1:0] limit_q;
  logic [LIMIT_W-1:0] limit_d;
  logic               queue_en_q;
  logic               queue_en_d;

  // monitor state
  logic               rate_flag_q;
  logic               rate_flag_d;
  logic [LIMIT_W-1:0] gap_q;
  logic [LIMIT_W-1:0] gap_d;
  logic               seen_trig_q;
  logic               seen_trig_d;
  logic [TALLY_W-1:0] tally_q;
  logic [TALLY_W-1:0] tally_d;
  logic               absent_q;
  logic               absent_d;
  logic               armed_q;
  logic               armed_d;
  logic               frame_seen_q;
  logic               frame_seen_d;

  // decoded bus and monitor events
  logic               access;
  logic               wr_take;
  logic               rd_take;
  logic               hit;
  logic               clr_rate;
  logic               clr_tally;
  logic               clr_absent;
  logic               start_edge;
  logic               too_fast;
  logic               overrun_evt;
  logic               missing_evt;
  logic [DATA_W-1:0]  rd_word;

  tmon_edge_sel #(
    .NUM (NUM_GEN),
    .SW  (SEL_W)
  ) u_edge (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .pulse_former (pulse_former),
    .sel          (source_q),      // [R10]
    .start_edge   (start_edge)
  );

  // ---------------- apb decode ----------------
  // one wait state: pready rises in the second access cycle
  assign access  = psel & penable;
  assign wr_take = access & pready_q & pwrite;
  assign rd_take = access & ~pready_q & ~pwrite;

  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      OFS_SOURCE: hit = 1'b1;
      OFS_STATUS: hit = 1'b1;
      OFS_CLEAR:  hit = 1'b1;
      OFS_TALLY:  hit = 1'b1;
      OFS_LIMIT:  hit = 1'b1;
      OFS_QUEUE:  hit = 1'b1;
      default:    hit = 1'b0;
    endcase
  end

  // clear commands are write-only strobes of the clear register
  assign clr_rate   = wr_take & hit & (paddr == OFS_CLEAR)
                      & pwdata[CLR_RATE_BIT];
  assign clr_tally  = wr_take & hit & (paddr == OFS_CLEAR)
                      & pwdata[CLR_TALLY_BIT];
  assign clr_absent = wr_take & hit & (paddr == OFS_CLEAR)
                      & pwdata[CLR_ABSENT_BIT];

  // read mux; clear register reads as zero
  always_comb begin
    rd_word = '0;
    unique case (paddr)
      OFS_SOURCE: rd_word[SEL_W-1:0] = source_q;
      OFS_STATUS: begin
        rd_word[STS_RATE_BIT]   = rate_flag_q;   // [R03]
        rd_word[STS_ABSENT_BIT] = absent_q;
      end
      OFS_TALLY:  rd_word[TALLY_W-1:0] = tally_q;
      OFS_LIMIT:  rd_word[LIMIT_W-1:0] = limit_q;
      OFS_QUEUE:  rd_word[QUEUE_EN_BIT] = queue_en_q;
      default:    rd_word = '0;
    endcase
  end

  always_comb begin
    pready_d  = pready_q;
    pslverr_d = pslverr_q;
    prdata_d  = prdata_q;
    if (ce) begin
      pready_d  = access & ~pready_q;
      pslverr_d = access & ~pready_q & ~hit;
      if (rd_take) begin
        prdata_d = rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ---------------- settings ----------------
  always_comb begin
    source_d   = source_q;
    limit_d    = limit_q;
    queue_en_d = queue_en_q;
    if (ce && wr_take && hit) begin
      unique case (paddr)
        OFS_SOURCE: source_d   = pwdata[SEL_W-1:0];   // [R05]
        OFS_LIMIT:  limit_d    = pwdata[LIMIT_W-1:0];
        OFS_QUEUE:  queue_en_d = pwdata[QUEUE_EN_BIT];
        default:    source_d   = source_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_q   <= RST_SOURCE;                        // [R05]
      limit_q    <= RST_LIMIT;
      queue_en_q <= 1'b0;
    end else begin
      source_q   <= source_d;
      limit_q    <= limit_d;
      queue_en_q <= queue_en_d;
    end
  end

  // ---------------- rate overrun ----------------
  // limit is the least period in cycles; zero disables the check
  assign too_fast = seen_trig_q & (limit_q != '0) & (gap_q < limit_q);

  always_comb begin
    if (queue_en_q) begin
      overrun_evt = trig_in_pulse & queue_full;           // [R02]
    end else begin
      overrun_evt = trig_in_pulse & too_fast;             // [R01]
    end
  end

  always_comb begin
    gap_d       = gap_q;
    seen_trig_d = seen_trig_q;
    rate_flag_d = rate_flag_q;
    if (ce) begin
      if (trig_in_pulse) begin
        // gap restarts at one so a pulse exactly limit apart passes
        gap_d       = {{(LIMIT_W-1){1'b0}}, 1'b1};
        seen_trig_d = 1'b1;
      end else if (gap_q != {LIMIT_W{1'b1}}) begin
        gap_d = gap_q + 1'b1;
      end
      // set beats clear in the same cycle
      if (overrun_evt) begin
        rate_flag_d = 1'b1;                                // [R01]
      end else if (clr_rate) begin
        rate_flag_d = 1'b0;                                // [R04]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q       <= '0;
      seen_trig_q <= 1'b0;
      rate_flag_q <= 1'b0;
    end else begin
      gap_q       <= gap_d;
      seen_trig_q <= seen_trig_d;
      rate_flag_q <= rate_flag_d;
    end
  end

  // ---------------- output pulse tally ----------------
  always_comb begin
    tally_d = tally_q;
    if (ce) begin
      if (clr_tally) begin
        tally_d = '0;                                      // [R07]
      end else if (start_edge && tally_q != TALLY_MAX) begin
        tally_d = tally_q + 1'b1;                          // [R06]
      end
      // saturates: a wrapped count would look like few pulses [R12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tally_q <= '0;
    end else begin
      tally_q <= tally_d;
    end
  end

  // ---------------- missing frame ----------------
  // a frame in the same cycle as an edge counts as between them
  assign missing_evt = start_edge & armed_q & ~frame_seen_q
                       & ~frame_valid;                     // [R08]

  always_comb begin
    armed_d      = armed_q;
    frame_seen_d = frame_seen_q;
    absent_d     = absent_q;
    if (ce) begin
      if (start_edge) begin
        armed_d      = 1'b1;
        frame_seen_d = 1'b0;
      end else if (frame_valid) begin
        frame_seen_d = 1'b1;                               // [R13]
      end
      if (missing_evt) begin
        absent_d = 1'b1;                                   // [R08]
      end else if (clr_absent) begin
        absent_d = 1'b0;                                   // [R09]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q      <= 1'b0;
      frame_seen_q <= 1'b0;
      absent_q     <= 1'b0;
    end else begin
      armed_q      <= armed_d;
      frame_seen_q <= frame_seen_d;
      absent_q     <= absent_d;
    end
  end

  // ---------------- outputs ----------------
  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign rate_overrun_flag = rate_flag_q;
  assign absent_frame_flag = absent_q;
  assign queue_enable      = queue_en_q;

endmodule

// [bench/tmon_chk_assertions.sv]
// concurrent checks on the trigger output monitor ports
`timescale 1ns/1ps
module tmon_chk
  import tmon_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  ce,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_W-1:0]     paddr,
  input wire logic [DATA_W-1:0]     pwdata,
  input wire logic [DATA_W-1:0]     prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [NUM_GEN-1:0]    pulse_former,
  input wire logic                  trig_in_pulse,
  input wire logic                  queue_full,
  input wire logic                  frame_valid,
  input wire logic                  rate_overrun_flag,
  input wire logic                  absent_frame_flag,
  input wire logic                  queue_enable
);
  logic [SEL_W-1:0]   sel_q;
  logic [SEL_W-1:0]   sel_d;
  logic [NUM_GEN-1:0] pf_q;
  logic               acc;
  logic               wr_clr;
  logic               rd_src;
  logic               start;
  assign acc    = psel && penable && pready;
  assign wr_clr = acc && pwrite && paddr == OFS_CLEAR;
  assign rd_src = acc && !pwrite && paddr == OFS_SOURCE;
  assign start  = pulse_former[sel_q] && !pf_q[sel_q];
  // shadow of the selector, so edges can be tied to their generator
  always_comb begin
    sel_d = sel_q;
    if (ce && acc && pwrite && paddr == OFS_SOURCE)
      sel_d = pwdata[SEL_W-1:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= RST_SOURCE;
      pf_q  <= '0;
    end else if (ce) begin
      sel_q <= sel_d;
      pf_q  <= pulse_former;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);
  rate_hold_a: assert property (rate_overrun_flag &&
    !(wr_clr && pwdata[CLR_RATE_BIT]) |=> rate_overrun_flag)
    else $error("rate flag dropped without clear");
  rate_fall_a: assert property ($fell(rate_overrun_flag) |->
    $past(wr_clr && pwdata[CLR_RATE_BIT])) else $error("rate flag fell");
  rate_cause_a: assert property ($rose(rate_overrun_flag) |->
    $past(trig_in_pulse)) else $error("rate flag without pulse");
  queue_gate_a: assert property (queue_enable && trig_in_pulse &&
    !queue_full && !rate_overrun_flag |=> !rate_overrun_flag)
    else $error("rate flag set with room in queue");
  absent_hold_a: assert property (absent_frame_flag &&
    !(wr_clr && pwdata[CLR_ABSENT_BIT]) |=> absent_frame_flag)
    else $error("missing flag dropped without clear");
  absent_fall_a: assert property ($fell(absent_frame_flag) |->
    $past(wr_clr && pwdata[CLR_ABSENT_BIT])) else $error("missing fell");
  absent_cause_a: assert property ($rose(absent_frame_flag) |->
    $past(start, 2)) else $error("missing flag without start edge");
  source_read_a: assert property (rd_src |->
    prdata == {30'h0, sel_q}) else $error("selector readback wrong");
  wait_state_a: assert property (psel && !penable ##1 psel && penable
    |-> !pready ##1 pready) else $error("pready not on second access");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule

// [bench/tmon_cam_model.sv]
// camera model: answers each trigger start edge with one frame event unless drop is set or another edge arrives within dly cycles
`timescale 1ns/1ps
module tmon_cam_model (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       trig,
  input wire logic       drop,
  input wire logic [3:0] dly,
  output logic           frame_valid
);
  logic       t_q;
  logic [4:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_q         <= 1'b0;
      cnt_q       <= 5'h00;
      frame_valid <= 1'b0;
    end else begin
      t_q         <= trig;
      frame_valid <= cnt_q == 5'h01;
      // a dropped frame models a camera that lost the trigger
      if (trig && !t_q && !drop)
        cnt_q <= {1'b0, dly} + 5'h01;
      else if (cnt_q != 5'h00)
        cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule

// [bench/tb_top.sv]
// self-checking bench for the trigger output monitor
`timescale 1ns/1ps
module tb_top;
  import tmon_pkg::*;
  logic               pclk = 0, presetn = 0, ce = 1;
  logic               psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0]  paddr = '0;
  logic [DATA_W-1:0]  pwdata = '0, prdata;
  logic               pready, pslverr, frame_valid, drop = 0;
  logic               trig_in_pulse = 0, queue_full = 0;
  logic               rate_overrun_flag, absent_frame_flag, queue_enable;
  logic [NUM_GEN-1:0] pulse_former = '0, m;
  logic [3:0]         dly = 4'h1;
  logic [32:0]        expq[$];
  int                 fails = 0, n_tests = 0, seed = 74, n, k;
  always #2.5 pclk = ~pclk;
  tmon_top u_tmon_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pulse_former,
    .trig_in_pulse, .queue_full, .frame_valid, .rate_overrun_flag,
    .absent_frame_flag, .queue_enable);
  tmon_cam_model u_tmon_cam_model (.pclk, .presetn,
    .trig(pulse_former[0]), .drop, .dly, .frame_valid);
  task tally_and_finish;
    $display("mismatches %0d compares %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input logic [32:0] e);
    n_tests++;
    if ({pslverr, prdata} !== e) begin
      fails++;
      $display("BAD %0t read %h want %h", $time, {pslverr, prdata}, e);
    end
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp(expq.pop_front());
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      fails++;
      $display("BAD %0t no pready", $time);
      tally_and_finish;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task gp(input logic [3:0] mk, input int gap);
    @(posedge pclk) pulse_former <= mk;
    @(posedge pclk) pulse_former <= '0;
    repeat (gap) @(posedge pclk);
  endtask
  task tp(input int num, input int gap);
    repeat (num) begin
      @(posedge pclk) trig_in_pulse <= 1'b1;
      @(posedge pclk) trig_in_pulse <= 1'b0;
      repeat (gap - 2) @(posedge pclk);
    end
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_SOURCE, 33'h0);
    rd(OFS_STATUS, 33'h0);
    rd(OFS_CLEAR, 33'h0);
    rd(8'h40, 33'h1_00000000);
    for (k = 0; k < 4; k++) begin
      wr(OFS_SOURCE, 32'(k));
      rd(OFS_SOURCE, 33'(k));
      n = 0;
      repeat (6) begin
        m = 4'($random(seed));
        gp(m, 3);
        n += m[k];
      end
      rd(OFS_TALLY, 33'(n));
      wr(OFS_CLEAR, 32'h7);
      rd(OFS_TALLY, 33'h0);
    end
    // slow camera on generator 0, the camera trigger line
    dly <= 4'h6;
    wr(OFS_SOURCE, 32'h0);
    gp(4'h1, 10);
    wr(OFS_CLEAR, 32'h4);
    repeat (3) gp(4'h1, 10);
    rd(OFS_STATUS, 33'h0);
    drop <= 1'b1;
    repeat (2) gp(4'h1, 10);
    rd(OFS_STATUS, 33'h2);
    rd(OFS_STATUS, 33'h2);
    wr(OFS_CLEAR, 32'h4);
    rd(OFS_STATUS, 33'h0);
    drop <= 1'b0;
    wr(OFS_LIMIT, 32'h8);
    rd(OFS_LIMIT, 33'h8);
    tp(3, 8);
    rd(OFS_STATUS, 33'h0);
    tp(2, 7);
    rd(OFS_STATUS, 33'h1);
    rd(OFS_STATUS, 33'h1);
    wr(OFS_CLEAR, 32'h1);
    rd(OFS_STATUS, 33'h0);
    wr(OFS_QUEUE, 32'h1);
    rd(OFS_QUEUE, 33'h1);
    tp(3, 3);
    rd(OFS_STATUS, 33'h0);
    queue_full <= 1'b1;
    tp(1, 4);
    rd(OFS_STATUS, 33'h1);
    wr(OFS_SOURCE, 32'h3);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_STATUS, 33'h0);
    rd(OFS_SOURCE, 33'h0);
    repeat (4) @(posedge pclk);
    tally_and_finish;
  end
endmodule
bind tmon_top tmon_chk u_chk (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pulse_former,
  .trig_in_pulse, .queue_full, .frame_valid, .rate_overrun_flag,
  .absent_frame_flag, .queue_enable);
